// File: adsf_regs.svh
// Constants for the serial frame and mode controller
`ifndef ADSF_REGS_SVH
`define ADSF_REGS_SVH
`define ADSF_CMD_BITS          16
`define ADSF_DATA_BITS         14
`define ADSF_SHIFT_BITS        16
`define ADSF_CMD_HOLD          16'h0000
`define ADSF_CMD_STANDBY       16'h8200
`define ADSF_CMD_POWER_DOWN    16'h8300
`define ADSF_CMD_AUTO_SCAN     16'ha000
`define ADSF_CMD_MAN_BASE      16'hc000
`define ADSF_CMD_MAN_MASK      16'hfc00
`define ADSF_CMD_RESET         16'h8500
`define ADSF_CONV_TIME_NS      2000
`define ADSF_CONV_CYCLES       ((`ADSF_CONV_TIME_NS + 24) / 25)
`define ADSF_CH_BITS           3
`define ADSF_REGISTER_PROGRAM_MODE_BIT          15
`endif

// File: adsf_pkg.sv
// Types of the serial frame and mode controller
package adsf_pkg;
	typedef enum logic [5:0] {
		MODE_IDLE     = 6'b000001,
		MODE_STANDBY  = 6'b000010,
		MODE_PWRDOWN  = 6'b000100,
		MODE_AUTO     = 6'b001000,
		MODE_MANUAL   = 6'b010000,
		MODE_INVALID  = 6'b100000
	} adsf_mode_type;
endpackage

// File: adsf_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module adsf_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             reset_n,
	// Data
	input  wire logic [WIDTH-1:0] asyncIn,
	output var  logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_syncOut;

	always_comb begin
		next_stage1 = asyncIn;
		next_syncOut = stage1;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1 <= '0;
			syncOut <= '0;
		end else begin
			stage1 <= next_stage1;
			syncOut <= next_syncOut;
		end
	end
endmodule
`default_nettype wire

// File: adsf_converter.sv
// Conversion timer that loads the padded result word
`timescale 1ns/1ps
`default_nettype none
`include "adsf_regs.svh"
module adsf_converter #(
	parameter int CONV_CYCLES = `ADSF_CONV_CYCLES
) (
	// Clock and reset
	input  wire logic                       sys_clk,
	input  wire logic                       reset_n,
	// Control
	input  wire logic                       start,
	input  wire logic [`ADSF_DATA_BITS-1:0] sample,
	// Result
	output var  logic                       done,
	output var  logic [`ADSF_SHIFT_BITS-1:0] result
);
	logic [15:0]                  count;
	logic [15:0]                  next_count;
	logic                         busy;
	logic                         next_busy;
	logic                         next_done;
	logic [`ADSF_SHIFT_BITS-1:0]  next_result;
	logic [`ADSF_DATA_BITS-1:0]   held;
	logic [`ADSF_DATA_BITS-1:0]   next_held;

	always_comb begin
		next_count = count;
		next_busy = busy;
		next_done = 1'b0;
		next_result = result;
		next_held = held;
		if (start) begin
			next_held = sample;
			next_busy = 1'b1;
			next_count = 16'(CONV_CYCLES);
		end else if (busy) begin
			if (count <= 16'h0001) begin
				next_busy = 1'b0;
				next_done = 1'b1;
				next_result = {held, 2'b00};
			end else begin
				next_count = count - 16'h0001;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			count <= 16'h0000;
			busy <= 1'b0;
			done <= 1'b0;
			result <= 16'h0000;
			held <= 14'h0000;
		end else begin
			count <= next_count;
			busy <= next_busy;
			done <= next_done;
			result <= next_result;
			held <= next_held;
		end
	end
endmodule
`default_nettype wire

// File: adsf_frame_ctrl.sv
// Serial frame handling and operating-mode control
// Contract
// - Chip select fall samples channel, starts conversion in auto or manual mode
// - First sixteen clocks carry next command
// - Output held low during command phase
// - Result word is fourteen bits plus 00
// - Sixteenth falling edge presents result MSB
// - Later edges shift chain input through
// - Output released when chip select high
// - Idle after power-up until commanded
// - Program registers default; host configures first
// - All-zero word keeps last mode
// - All-zero in invalid state returns to idle
// - Command executes after sixteenth edge
// - Early chip select rise means invalid state
// - Invalid state returns invalid data, alarm kept
// - Standby word enters standby at rise
// - Standby held until conversion, power-down or reset command, or early rise
// - Standby long frames give invalid data
// - Conversion command leaves standby at rise
// - Standby exit keeps program registers
// - Input captured on first sixteen falls
// - Changes apply at next chip select fall
`timescale 1ns/1ps
`default_nettype none
`include "adsf_regs.svh"
module adsf_frame_ctrl #(
	parameter int NUM_CH      = 8,
	parameter int CONV_CYCLES = `ADSF_CONV_CYCLES
) (
	// Clock and reset
	input  wire logic                        sys_clk,
	input  wire logic                        reset_n,
	// Serial pins
	input  wire logic                        chipSel_n,
	input  wire logic                        serClk,
	input  wire logic                        serIn,
	input  wire logic                        chainIn,
	output var  logic                        serOut,
	output var  logic                        serOutEn_n,
	// Converter side
	input  wire logic [`ADSF_DATA_BITS-1:0]  sampleData,
	input  wire logic [NUM_CH-1:0]           autoSeq,
	output var  logic                        sampleStrobe,
	output var  logic [`ADSF_CH_BITS-1:0]    sampleChannel,
	output var  logic [`ADSF_CH_BITS-1:0]    alarmChannel,
	output var  logic                        refPowered,
	output var  logic                        convPowered,
	// Program register access and mode state
	output var  logic                        progStrobe,
	output var  logic [`ADSF_CMD_BITS-1:0]   progWord,
	output var  logic [2:0]                  modeState
);
	logic [2:0]                     pins;
	logic                           csSync;
	logic                           sclkSync;
	logic                           sdiSync;
	logic                           chainSync;
	logic                           csPrev;
	logic                           sclkPrev;
	logic                           next_csPrev;
	logic                           next_sclkPrev;
	logic                           csFall;
	logic                           csRise;
	logic                           sclkFall;
	logic [7:0]                     edgeCount;
	logic [7:0]                     next_edgeCount;
	logic [`ADSF_CMD_BITS-1:0]      cmdShift;
	logic [`ADSF_CMD_BITS-1:0]      next_cmdShift;
	logic [`ADSF_CMD_BITS-1:0]      pending;
	logic [`ADSF_CMD_BITS-1:0]      next_pending;
	logic                           cmdValid;
	logic                           next_cmdValid;
	logic [`ADSF_SHIFT_BITS-1:0]    outShift;
	logic [`ADSF_SHIFT_BITS-1:0]    next_outShift;
	logic                           next_serOut;
	logic                           next_serOutEn_n;
	adsf_pkg::adsf_mode_type        mode;
	adsf_pkg::adsf_mode_type        next_mode;
	logic                           converting;
	logic                           next_converting;
	logic                           dataGood;
	logic                           next_dataGood;
	logic [`ADSF_CH_BITS-1:0]       channel;
	logic [`ADSF_CH_BITS-1:0]       next_channel;
	logic [`ADSF_CH_BITS-1:0]       nextAuto;
	logic                           next_sampleStrobe;
	logic [`ADSF_CH_BITS-1:0]       next_sampleChannel;
	logic [`ADSF_CH_BITS-1:0]       next_alarmChannel;
	logic                           next_refPowered;
	logic                           next_convPowered;
	logic                           next_progStrobe;
	logic [`ADSF_CMD_BITS-1:0]      next_progWord;
	logic [2:0]                     next_modeState;
	logic                           convDone;
	logic [`ADSF_SHIFT_BITS-1:0]    convResult;
	logic [`ADSF_CMD_BITS-1:0]      word;

	adsf_sync #(
		.WIDTH(3)
	) pinSync (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.asyncIn({serClk, serIn, chainIn}),
		.syncOut(pins)
	);

	// Chip select synchronised apart so it idles high after reset
	logic csMeta;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			csMeta <= 1'b1;
			csSync <= 1'b1;
		end else begin
			csMeta <= chipSel_n;
			csSync <= csMeta;
		end
	end

	assign sclkSync = pins[2];
	assign sdiSync = pins[1];
	assign chainSync = pins[0];

	adsf_converter #(
		.CONV_CYCLES(CONV_CYCLES)
	) conv (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.start(next_sampleStrobe),
		.sample(sampleData),
		.done(convDone),
		.result(convResult)
	);

	// Next channel of the auto-scan sequence after the current one
	function automatic logic [`ADSF_CH_BITS-1:0] seqNext(
		input logic [NUM_CH-1:0]        sel,
		input logic [`ADSF_CH_BITS-1:0] cur,
		input logic                     restart
	);
		logic [`ADSF_CH_BITS-1:0] first;
		logic [`ADSF_CH_BITS-1:0] after;
		logic                     gotFirst;
		logic                     gotAfter;
		first = '0;
		after = '0;
		gotFirst = 1'b0;
		gotAfter = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (sel[i] && !gotFirst) begin
				first = `ADSF_CH_BITS'(i);
				gotFirst = 1'b1;
			end
			if (sel[i] && !gotAfter && `ADSF_CH_BITS'(i) > cur) begin
				after = `ADSF_CH_BITS'(i);
				gotAfter = 1'b1;
			end
		end
		return (restart || !gotAfter) ? first : after;
	endfunction

	always_comb begin
		csFall = csPrev && !csSync;
		csRise = !csPrev && csSync;
		sclkFall = sclkPrev && !sclkSync && !csSync;
		next_csPrev = csSync;
		next_sclkPrev = sclkSync;
		next_edgeCount = edgeCount;
		next_cmdShift = cmdShift;
		next_pending = pending;
		next_cmdValid = cmdValid;
		next_outShift = outShift;
		next_serOut = serOut;
		next_serOutEn_n = serOutEn_n;
		next_mode = mode;
		next_converting = converting;
		next_dataGood = dataGood;
		next_channel = channel;
		next_sampleStrobe = 1'b0;
		next_sampleChannel = sampleChannel;
		next_alarmChannel = alarmChannel;
		next_progStrobe = 1'b0;
		next_progWord = progWord;
		word = {cmdShift[`ADSF_CMD_BITS-2:0], sdiSync};
		nextAuto = seqNext(autoSeq, channel, 1'b0);
		if (csSync) begin
			next_serOutEn_n = 1'b1;
			next_serOut = 1'b0;
		end
		if (csFall) begin
			next_edgeCount = 8'h00;
			next_serOutEn_n = 1'b0;
			next_serOut = 1'b0;
			next_cmdValid = 1'b0;
			next_dataGood = 1'b0;
			next_converting = 1'b0;
			// Settings of the last frame apply here
			if (mode == adsf_pkg::MODE_AUTO ||
				mode == adsf_pkg::MODE_MANUAL) begin
				next_sampleStrobe = 1'b1;
				next_converting = 1'b1;
				next_sampleChannel = channel;
				next_alarmChannel = channel;
				if (mode == adsf_pkg::MODE_AUTO) begin
					next_channel = nextAuto;
				end
			end
		end
		if (convDone && converting) begin
			next_outShift = convResult;
			next_dataGood = 1'b1;
		end
		if (sclkFall) begin
			if (edgeCount != 8'hff) begin
				next_edgeCount = edgeCount + 8'h01;
			end
			if (edgeCount < 8'(`ADSF_CMD_BITS)) begin
				next_cmdShift = word;
			end
			if (edgeCount == 8'(`ADSF_CMD_BITS - 1)) begin
				next_pending = word;
				next_cmdValid = 1'b1;
				// Invalid when no conversion ran in this frame
				// MSB stays in place; chain bits enter from the next edge
				next_serOut = dataGood ? outShift[`ADSF_SHIFT_BITS-1]
					: 1'b1;
				if (word[`ADSF_REGISTER_PROGRAM_MODE_BIT] == 1'b0 &&
					word != `ADSF_CMD_HOLD) begin
					next_progStrobe = 1'b1;
					next_progWord = word;
				end
			end else if (edgeCount >= 8'(`ADSF_CMD_BITS)) begin
				next_serOut = dataGood ? outShift[`ADSF_SHIFT_BITS-2]
					: 1'b1;
				next_outShift = {outShift[`ADSF_SHIFT_BITS-2:0],
					chainSync};
			end else begin
				next_serOut = 1'b0;
			end
		end
		if (csRise) begin
			if (!cmdValid) begin
				next_mode = adsf_pkg::MODE_INVALID;
			end else if (pending == `ADSF_CMD_HOLD) begin
				// Hold keeps mode, also after programming; in invalid go idle
				if (mode == adsf_pkg::MODE_INVALID) begin
					next_mode = adsf_pkg::MODE_IDLE;
				end
			end else if (pending == `ADSF_CMD_STANDBY) begin
				next_mode = adsf_pkg::MODE_STANDBY;
			end else if (pending == `ADSF_CMD_POWER_DOWN) begin
				next_mode = adsf_pkg::MODE_PWRDOWN;
			end else if (pending == `ADSF_CMD_RESET) begin
				next_mode = adsf_pkg::MODE_IDLE;
			end else if (pending == `ADSF_CMD_AUTO_SCAN) begin
				next_mode = adsf_pkg::MODE_AUTO;
				next_channel = seqNext(autoSeq, channel, 1'b1);
			end else if ((pending & `ADSF_CMD_MAN_MASK) ==
				`ADSF_CMD_MAN_BASE) begin
				next_mode = adsf_pkg::MODE_MANUAL;
				next_channel = pending[`ADSF_CH_BITS+6:7];
			end else if (mode == adsf_pkg::MODE_INVALID) begin
				next_mode = adsf_pkg::MODE_IDLE;
			end
		end
		next_refPowered = (next_mode != adsf_pkg::MODE_PWRDOWN);
		next_convPowered = (next_mode == adsf_pkg::MODE_AUTO ||
			next_mode == adsf_pkg::MODE_MANUAL);
		case (next_mode)
			adsf_pkg::MODE_IDLE:    next_modeState = 3'h0;
			adsf_pkg::MODE_STANDBY: next_modeState = 3'h1;
			adsf_pkg::MODE_PWRDOWN: next_modeState = 3'h2;
			adsf_pkg::MODE_AUTO:    next_modeState = 3'h3;
			adsf_pkg::MODE_MANUAL:  next_modeState = 3'h4;
			default:                next_modeState = 3'h5;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			csPrev <= 1'b1;
			sclkPrev <= 1'b0;
			edgeCount <= 8'h00;
			cmdShift <= 16'h0000;
			pending <= 16'h0000;
			cmdValid <= 1'b0;
			outShift <= 16'h0000;
			serOut <= 1'b0;
			serOutEn_n <= 1'b1;
			mode <= adsf_pkg::MODE_IDLE;
			converting <= 1'b0;
			dataGood <= 1'b0;
			channel <= 3'h0;
			sampleStrobe <= 1'b0;
			sampleChannel <= 3'h0;
			alarmChannel <= 3'h0;
			refPowered <= 1'b1;
			convPowered <= 1'b0;
			progStrobe <= 1'b0;
			progWord <= 16'h0000;
			modeState <= 3'h0;
		end else begin
			csPrev <= next_csPrev;
			sclkPrev <= next_sclkPrev;
			edgeCount <= next_edgeCount;
			cmdShift <= next_cmdShift;
			pending <= next_pending;
			cmdValid <= next_cmdValid;
			outShift <= next_outShift;
			serOut <= next_serOut;
			serOutEn_n <= next_serOutEn_n;
			mode <= next_mode;
			converting <= next_converting;
			dataGood <= next_dataGood;
			channel <= next_channel;
			sampleStrobe <= next_sampleStrobe;
			sampleChannel <= next_sampleChannel;
			alarmChannel <= next_alarmChannel;
			refPowered <= next_refPowered;
			convPowered <= next_convPowered;
			progStrobe <= next_progStrobe;
			progWord <= next_progWord;
			modeState <= next_modeState;
		end
	end
endmodule
`default_nettype wire

// File: adsf_frame_props.sv
// Assertions on the frame controller ports
`timescale 1ns/1ps
`default_nettype none
`include "adsf_regs.svh"
module adsf_frame_props #(
	parameter int NUM_CH      = 8,
	parameter int CONV_CYCLES = 80
) (
	// Clock and reset
	input wire logic                     sys_clk,
	input wire logic                     reset_n,
	// Serial pins
	input wire logic                     chipSel_n,
	input wire logic                     serClk,
	input wire logic                     serOut,
	input wire logic                     serOutEn_n,
	// Status
	input wire logic                     sampleStrobe,
	input wire logic [`ADSF_CH_BITS-1:0] alarmChannel,
	input wire logic                     refPowered,
	input wire logic                     convPowered,
	input wire logic                     progStrobe,
	input wire logic [2:0]               modeState
);
	logic       clkPrev;
	logic [7:0] fallCnt;
	logic [7:0] next_fallCnt;
	// Counts serial clock falls at the pins within a frame
	always_comb begin
		next_fallCnt = fallCnt;
		if (chipSel_n)
			next_fallCnt = 8'h00;
		else if (clkPrev && !serClk && fallCnt != 8'hff)
			next_fallCnt = fallCnt + 8'h01;
	end
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			clkPrev <= 1'h1;
			fallCnt <= 8'h00;
		end else begin
			clkPrev <= serClk;
			fallCnt <= next_fallCnt;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_release_idle: assert property (chipSel_n [*6] |-> serOutEn_n)
		else $error("output not released outside frame");
	a_drive_frame: assert property ((!chipSel_n) [*6] |-> !serOutEn_n)
		else $error("output not driven in frame");
	a_low_before_msb: assert property (
		(!chipSel_n && fallCnt < 8'h0f) [*6] |-> !serOut)
		else $error("output not low in command phase");
	a_strobe_after_fall: assert property (sampleStrobe |->
		!chipSel_n && !$past(chipSel_n, 2) && $past(chipSel_n, 6)
		##1 !sampleStrobe)
		else $error("sample strobe not tied to select fall");
	a_strobe_in_conv: assert property (sampleStrobe |->
		modeState == 3'h3 || modeState == 3'h4)
		else $error("sample outside converting mode");
	a_register_program_mode_after_last: assert property (
		progStrobe |-> fallCnt == 8'h10 ##1 !progStrobe)
		else $error("program word not at sixteenth fall");
	a_mode_at_rise: assert property ($changed(modeState) |->
		chipSel_n && !$past(chipSel_n, 6))
		else $error("mode changed away from select rise");
	a_standby_power: assert property (
		(modeState == 3'h1) [*3] |-> refPowered && !convPowered)
		else $error("standby power levels wrong");
	a_conv_power: assert property (
		(modeState == 3'h3 || modeState == 3'h4) [*3] |-> convPowered)
		else $error("converter unpowered in scan mode");
	a_alarm_kept: assert property (
		modeState == 3'h5 && $past(modeState) == 3'h5
		|-> $stable(alarmChannel))
		else $error("alarm channel moved in invalid state");
endmodule
bind adsf_frame_ctrl adsf_frame_props #(
	.NUM_CH(NUM_CH),
	.CONV_CYCLES(CONV_CYCLES)
) props (
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.chipSel_n(chipSel_n),
	.serClk(serClk),
	.serOut(serOut),
	.serOutEn_n(serOutEn_n),
	.sampleStrobe(sampleStrobe),
	.alarmChannel(alarmChannel),
	.refPowered(refPowered),
	.convPowered(convPowered),
	.progStrobe(progStrobe),
	.modeState(modeState)
);
`default_nettype wire

// File: adsf_host_model.sv
// Host controller that runs serial frames
`timescale 1ns/1ps
`default_nettype none
module adsf_host_model (
	// Clock
	input  wire logic sys_clk,
	// Serial pins
	output var  logic chipSel_n,
	output var  logic serClk,
	output var  logic serIn,
	output var  logic chainIn,
	input  wire logic serOut,
	input  wire logic serOutEn_n
);
	initial begin
		chipSel_n = 1'h1;
		serClk = 1'h1;
		serIn = 1'h0;
		chainIn = 1'h0;
	end
	// One frame of n clocks; a released line reads as the inverse
	task automatic frame(input logic [15:0] cmd, input int n,
		input logic [15:0] chain, output logic [63:0] got);
		got = 64'h0;
		@(negedge sys_clk) chipSel_n = 1'h0;
		repeat (8) @(negedge sys_clk);
		for (int k = 1; k <= n; k++) begin
			serIn = (k <= 16) ? cmd[16-k] : 1'h0;
			chainIn = (k > 16 && k <= 32) ? chain[32-k] : 1'h0;
			repeat (4) @(negedge sys_clk);
			serClk = 1'h0;
			repeat (4) @(negedge sys_clk);
			got = {got[62:0], serOutEn_n ? ~got[0] : serOut};
			serClk = 1'h1;
		end
		chipSel_n = 1'h1;
		serIn = 1'h0;
		chainIn = 1'h0;
		repeat (12) @(negedge sys_clk);
	endtask
endmodule
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the frame controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        sys_clk = 1'h0;
	logic        reset_n = 1'h0;
	logic        chipSel_n, serClk, serIn, chainIn;
	logic        serOut, serOutEn_n, sampleStrobe, refPowered;
	logic        convPowered, progStrobe;
	logic [2:0]  sampleChannel, alarmChannel, modeState;
	logic [15:0] progWord, lastProg;
	logic [63:0] got;
	int          errors = 0;
	int          checksDone = 0;
	int          strobes = 0;
	int          progs = 0;
	always #12.5 sys_clk = ~sys_clk;
	always @(negedge sys_clk) begin
		if (sampleStrobe)
			strobes++;
		if (progStrobe) begin
			progs++;
			lastProg = progWord;
		end
	end
	adsf_frame_ctrl #(.CONV_CYCLES(4)) dut (
		.sys_clk(sys_clk), .reset_n(reset_n), .chipSel_n(chipSel_n),
		.serClk(serClk), .serIn(serIn), .chainIn(chainIn),
		.serOut(serOut), .serOutEn_n(serOutEn_n),
		.sampleData(14'h2a5c), .autoSeq(8'h24),
		.sampleStrobe(sampleStrobe), .sampleChannel(sampleChannel),
		.alarmChannel(alarmChannel), .refPowered(refPowered),
		.convPowered(convPowered), .progStrobe(progStrobe),
		.progWord(progWord), .modeState(modeState)
	);
	adsf_host_model host (
		.sys_clk(sys_clk), .chipSel_n(chipSel_n), .serClk(serClk),
		.serIn(serIn), .chainIn(chainIn), .serOut(serOut),
		.serOutEn_n(serOutEn_n)
	);
	task automatic check(input string name, input logic [63:0] exp, act);
		checksDone++;
		if (act !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, act);
		end
	endtask
	task automatic fr(input logic [15:0] cmd, input int n);
		host.frame(cmd, n, 16'hc35a, got);
	endtask
	task automatic t_idle;
		check("mode", 3'h0, modeState);
		fr(16'h0000, 32);
		check("strobes", 0, strobes);
		check("oe", 1'h1, serOutEn_n);
		fr(16'h1234, 16);
		check("register_program_mode word", 16'h1234, lastProg);
		check("progs", 1, progs);
		fr(16'h0000, 16);
		check("mode", 3'h0, modeState);
	endtask
	task automatic t_auto;
		fr(16'ha000, 16);
		check("mode", 3'h3, modeState);
		check("conv", 1'h1, convPowered);
		check("strobes", 0, strobes);
		fr(16'h0000, 48);
		check("strobes", 1, strobes);
		check("chan", 3'h2, sampleChannel);
		check("cmd phase", 15'h0000, got[47:33]);
		check("word", 16'ha970, got[32:17]);
		check("chain", 16'hc35a, got[16:1]);
		check("mode", 3'h3, modeState);
		fr(16'h0000, 32);
		check("chan", 3'h5, sampleChannel);
	endtask
	task automatic t_standby;
		int s;
		fr(16'h8200, 16);
		s = strobes;
		check("mode", 3'h1, modeState);
		check("ref", 1'h1, refPowered);
		check("conv", 1'h0, convPowered);
		fr(16'h0000, 32);
		check("mode", 3'h1, modeState);
		check("strobes", s, strobes);
		check("data", 16'hffff, got[16:1]);
		fr(16'h1234, 16);
		check("progs", 2, progs);
		fr(16'hc180, 16);
		check("mode", 3'h4, modeState);
		repeat (800) @(negedge sys_clk);
		fr(16'h0000, 32);
		check("chan", 3'h3, sampleChannel);
		check("word", 16'ha970, got[16:1]);
	endtask
	task automatic t_abort;
		fr(16'ha000, 8);
		check("mode", 3'h5, modeState);
		fr(16'h0000, 32);
		check("data", 16'hffff, got[16:1]);
		check("alarm", 3'h3, alarmChannel);
		check("mode", 3'h0, modeState);
		fr(16'h8300, 16);
		check("ref", 1'h0, refPowered);
		fr(16'h0000, 16);
		check("mode", 3'h2, modeState);
		fr(16'h8500, 16);
		check("mode", 3'h0, modeState);
		check("ref", 1'h1, refPowered);
	endtask
	task automatic t_reset;
		reset_n = 1'h0;
		repeat (3) @(negedge sys_clk);
		check("mode", 3'h0, modeState);
		check("oe", 1'h1, serOutEn_n);
		reset_n = 1'h1;
		repeat (3) @(negedge sys_clk);
		fr(16'h0000, 16);
		check("mode", 3'h0, modeState);
	endtask
	task automatic closeOut;
		$display("checks %0d errors %0d", checksDone, errors);
		if (errors == 0 && checksDone > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge sys_clk);
		reset_n = 1'h1;
		repeat (3) @(negedge sys_clk);
		t_idle;
		t_auto;
		t_standby;
		t_abort;
		t_reset;
		closeOut;
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		errors++;
		closeOut;
	end
endmodule
`default_nettype wire
